// ---- hdl/mcrb_pkg.sv ----
// Constants for the second mode configuration register bank.
// Assumes an 8-bit page-0 register port driven by the bus front end.
package mcrb_pkg;

	localparam logic [1:0] PAGE_ZERO        = 2'h0;
	localparam logic [3:0] PHY_AND_BUS_OFS  = 4'hb;

	// Field positions
	localparam int PHY_TYPE_LSB             = 0;
	localparam int LINK_BIT                 = 2;
	localparam int WIDE_IO_BIT              = 3;
	localparam int READY_BIT                = 4;
	localparam int BUS_FAULT_BIT            = 5;
	localparam int ROM_WRITE_BIT            = 6;
	localparam int EEPROM_RELOAD_BIT        = 7;

	// Values after reset
	localparam logic [1:0] PHY_TYPE_RST     = 2'h0;
	localparam logic       LINK_DIS_RST     = 1'b0;
	localparam logic       WIDE_IO_RST      = 1'b0;
	localparam logic       READY_RST        = 1'b0;
	localparam logic       BUS_FAULT_RST    = 1'b0;
	localparam logic       ROM_WRITE_RST    = 1'b0;
	localparam logic [7:0] RDATA_RST        = 8'h00;

	// Stages in the pin synchroniser
	localparam int SYNC_STAGES              = 3;

	typedef enum logic [1:0]
	{
		MCRB_PHY_TP_STD   = 2'b00,
		MCRB_PHY_THIN     = 2'b01,
		MCRB_PHY_THICK    = 2'b10,
		MCRB_PHY_TP_LOW   = 2'b11
	} mcrb_phy_type;

endpackage : mcrb_pkg

// ---- hdl/mcrb_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the pin is asynchronous to clk_i.
module mcrb_pin_sync
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o
);

	logic [mcrb_pkg::SYNC_STAGES-1:0] stage_q;
	logic [mcrb_pkg::SYNC_STAGES-1:0] stage_d;
	logic                             level_q;
	logic                             level_d;

	always_comb
	begin
		stage_d = {stage_q[mcrb_pkg::SYNC_STAGES-2:0], pin_i};
		level_d = level_q;
		// First stage is left out on purpose: only stages two and three vote
		if (stage_q[1] == stage_q[2])
			level_d = stage_q[2];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stage_q <= '0;
			level_q <= 1'b0;
		end
		else
		begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level_o = level_q;

endmodule : mcrb_pin_sync

// ---- hdl/mcrb_config.sv ----
// Second mode configuration register with its guarded write sequence.
// Assumes one-cycle read and write strobes from the bus front end on clk_i
// and bus timing inputs already in the clk_i domain.

// Overview of operation
// - Read of page 0 offset 0BH returns contents; write lands only right after it
// - Any intervening access routes the 0BH write to remote byte count 1
// - Bits 0-1 pick TP standard, thin coax, thick coax, TP reduced squelch
// - Twisted pair modes use TP pins; coax modes use the AUI pins
// - Coax select pin is low for thick coax and high for thin coax
// - Reduced-squelch TP mode applies lower receive squelch thresholds
// - Writing one to bit 2 disables link pulses and link checking
// - Bit 2 reads back the link LED state
// - Bit 3 high gives wide IO indication after strobe, low on decode alone
// - Bit 4 low gives ready after command strobe, high after address latch
// - Bus fault flag sets when host ends a cycle ignoring wait states
// - Writing one clears the bus fault flag unless a fault sets it that cycle; zero leaves it
// - Bit 6 low blocks all write cycles toward the boot PROM
// - Writing one to bit 7 starts the EEPROM reload
module mcrb_config
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Page-0 register port
	input  wire logic       reg_rd_i,
	input  wire logic       reg_wr_i,
	input  wire logic [1:0] reg_page_i,
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic [7:0]      reg_rdata_o,
	output logic            reg_rdata_valid_o,
	output logic            remote_count1_wr_o,
	output logic [7:0]      remote_count1_wdata_o,
	// Transceiver side
	input  wire logic       link_integrity_pin_i,
	output logic [1:0]      phy_type_select_o,
	output logic            twisted_pair_mode_o,
	output logic            aui_select_o,
	output logic            coax_thin_o,
	output logic            squelch_reduced_o,
	output logic            link_test_disable_o,
	output logic            link_led_o,
	// Bus timing
	input  wire logic       addr_decode_i,
	input  wire logic       io_strobe_i,
	input  wire logic       cmd_strobe_i,
	input  wire logic       addr_latch_i,
	input  wire logic       wait_abort_i,
	output logic            wide_io_o,
	output logic            ready_start_o,
	// Boot PROM and EEPROM
	input  wire logic       rom_write_req_i,
	output logic            rom_write_o,
	output logic            eeprom_reload_trigger_o
);

	logic [1:0] phy_type_select_q;
	logic [1:0] phy_type_select_d;
	logic       link_disable_q;
	logic       link_disable_d;
	logic       wide_io_timing_select_q;
	logic       wide_io_timing_select_d;
	logic       ready_timing_select_q;
	logic       ready_timing_select_d;
	logic       bus_fault_flag_q;
	logic       bus_fault_flag_d;
	logic       rom_write_allow_q;
	logic       rom_write_allow_d;
	logic       armed_q;
	logic       armed_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rdata_valid_q;
	logic       rdata_valid_d;
	logic       rc1_wr_q;
	logic       rc1_wr_d;
	logic [7:0] rc1_wdata_q;
	logic [7:0] rc1_wdata_d;
	logic       reload_q;
	logic       reload_d;

	logic       link_sync;
	logic       hit;
	logic       is_coax;
	logic       link_status;
	logic [7:0] read_value;
	logic       rd_hit;
	logic       wr_hit;
	logic       wr_armed;
	logic       coax_thin;
	logic       squelch_reduced;

	mcrb_pin_sync u_link_sync
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (link_integrity_pin_i),
		.level_o (link_sync)
	);

	assign hit = (reg_page_i == mcrb_pkg::PAGE_ZERO)
		&& (reg_addr_i == mcrb_pkg::PHY_AND_BUS_OFS);

	// interface type decode
	// Every code spelled out so no mode lands in the wrong pin group
	always_comb
	begin
		is_coax         = 1'b0;
		coax_thin       = 1'b0;
		squelch_reduced = 1'b0;
		case (phy_type_select_q)
			mcrb_pkg::MCRB_PHY_TP_STD:
			begin
				is_coax = 1'b0;
			end
			mcrb_pkg::MCRB_PHY_THIN:
			begin
				is_coax   = 1'b1;
				coax_thin = 1'b1;
			end
			mcrb_pkg::MCRB_PHY_THICK:
			begin
				is_coax = 1'b1;
			end
			mcrb_pkg::MCRB_PHY_TP_LOW:
			begin
				squelch_reduced = 1'b1;
			end
			default:
			begin
				is_coax = 1'b0;
			end
		endcase
	end

	assign link_status = is_coax ? 1'b0 : (link_disable_q | link_sync);

	always_comb
	begin
		read_value = 8'h00;
		read_value[mcrb_pkg::PHY_TYPE_LSB +: 2] = phy_type_select_q;
		read_value[mcrb_pkg::LINK_BIT] = link_status;
		read_value[mcrb_pkg::WIDE_IO_BIT] = wide_io_timing_select_q;
		read_value[mcrb_pkg::READY_BIT] = ready_timing_select_q;
		read_value[mcrb_pkg::BUS_FAULT_BIT] = bus_fault_flag_q;
		read_value[mcrb_pkg::ROM_WRITE_BIT] = rom_write_allow_q;
	end

	// Access decode shared by the state groups
	assign rd_hit   = reg_rd_i && hit;
	assign wr_hit   = reg_wr_i && hit;
	assign wr_armed = wr_hit && armed_q;

	// Guard and read port group
	always_comb
	begin
		armed_d       = armed_q;
		rdata_d       = rdata_q;
		rdata_valid_d = 1'b0;
		rc1_wr_d      = 1'b0;
		rc1_wdata_d   = rc1_wdata_q;

		// armed flag tracking
		// Any other access disarms so a stale read cannot open a write
		if (reg_rd_i || reg_wr_i)
			armed_d = rd_hit;

		if (rd_hit)
		begin
			rdata_d       = read_value;
			rdata_valid_d = 1'b1;
		end

		if (wr_hit && !armed_q)
		begin
			rc1_wr_d    = 1'b1;
			rc1_wdata_d = reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			armed_q       <= 1'b0;
			rdata_q       <= mcrb_pkg::RDATA_RST;
			rdata_valid_q <= 1'b0;
			rc1_wr_q      <= 1'b0;
			rc1_wdata_q   <= 8'h00;
		end
		else
		begin
			armed_q       <= armed_d;
			rdata_q       <= rdata_d;
			rdata_valid_q <= rdata_valid_d;
			rc1_wr_q      <= rc1_wr_d;
			rc1_wdata_q   <= rc1_wdata_d;
		end
	end

	// Stored configuration group
	always_comb
	begin
		phy_type_select_d       = phy_type_select_q;
		link_disable_d          = link_disable_q;
		wide_io_timing_select_d = wide_io_timing_select_q;
		ready_timing_select_d   = ready_timing_select_q;
		rom_write_allow_d       = rom_write_allow_q;
		reload_d                = 1'b0;

		if (wr_armed)
		begin
			phy_type_select_d =
				reg_wdata_i[mcrb_pkg::PHY_TYPE_LSB +: 2];
			link_disable_d = reg_wdata_i[mcrb_pkg::LINK_BIT];
			wide_io_timing_select_d =
				reg_wdata_i[mcrb_pkg::WIDE_IO_BIT];
			ready_timing_select_d = reg_wdata_i[mcrb_pkg::READY_BIT];
			rom_write_allow_d = reg_wdata_i[mcrb_pkg::ROM_WRITE_BIT];
			reload_d = reg_wdata_i[mcrb_pkg::EEPROM_RELOAD_BIT];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			phy_type_select_q       <= mcrb_pkg::PHY_TYPE_RST;
			link_disable_q          <= mcrb_pkg::LINK_DIS_RST;
			wide_io_timing_select_q <= mcrb_pkg::WIDE_IO_RST;
			ready_timing_select_q   <= mcrb_pkg::READY_RST;
			rom_write_allow_q       <= mcrb_pkg::ROM_WRITE_RST;
			reload_q                <= 1'b0;
		end
		else
		begin
			phy_type_select_q       <= phy_type_select_d;
			link_disable_q          <= link_disable_d;
			wide_io_timing_select_q <= wide_io_timing_select_d;
			ready_timing_select_q   <= ready_timing_select_d;
			rom_write_allow_q       <= rom_write_allow_d;
			reload_q                <= reload_d;
		end
	end

	// Bus fault group
	always_comb
	begin
		bus_fault_flag_d = bus_fault_flag_q;
		if (wr_armed && reg_wdata_i[mcrb_pkg::BUS_FAULT_BIT])
			bus_fault_flag_d = 1'b0;
		// set beats clear
		// Set wins so a fault in the clearing cycle is never lost
		if (wait_abort_i)
			bus_fault_flag_d = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus_fault_flag_q <= mcrb_pkg::BUS_FAULT_RST;
		else
			bus_fault_flag_q <= bus_fault_flag_d;
	end

	assign reg_rdata_o           = rdata_q;
	assign reg_rdata_valid_o     = rdata_valid_q;
	assign remote_count1_wr_o    = rc1_wr_q;
	assign remote_count1_wdata_o = rc1_wdata_q;

	assign phy_type_select_o   = phy_type_select_q;
	assign twisted_pair_mode_o = ~is_coax;
	assign aui_select_o        = is_coax;
	assign coax_thin_o         = coax_thin;
	assign squelch_reduced_o   = squelch_reduced;
	assign link_test_disable_o = link_disable_q;
	assign link_led_o          = link_status;

	assign wide_io_o = addr_decode_i
		&& (!wide_io_timing_select_q || io_strobe_i);
	assign ready_start_o = ready_timing_select_q ? addr_latch_i
		: cmd_strobe_i;
	assign rom_write_o = rom_write_req_i && rom_write_allow_q;

	// Reload is a pulse so the bit never reads or stays high
	assign eeprom_reload_trigger_o = reload_q;

endmodule : mcrb_config

// ---- sim/mcrb_config_chk.sv ----
// Port checker for the second mode config register bank.
// Assumes binding into mcrb_config; one clock, sync reset.
module mcrb_config_chk
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       reg_rd_i,
	input wire logic       reg_wr_i,
	input wire logic [1:0] reg_page_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_rdata_valid_o,
	input wire logic       remote_count1_wr_o,
	input wire logic [7:0] remote_count1_wdata_o,
	input wire logic [1:0] phy_type_select_o,
	input wire logic       twisted_pair_mode_o,
	input wire logic       aui_select_o,
	input wire logic       coax_thin_o,
	input wire logic       link_led_o,
	input wire logic       addr_decode_i,
	input wire logic       io_strobe_i,
	input wire logic       wide_io_o,
	input wire logic       rom_write_req_i,
	input wire logic       rom_write_o,
	input wire logic       eeprom_reload_trigger_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       armed_q;
	logic [7:0] cfg_q;
	logic       hit;
	assign hit = reg_page_i == 2'h0 && reg_addr_i == 4'hb;
	// Shadow of the guard and stored bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i || reg_wr_i)
			armed_q <= 1'b0;
		else if (reg_rd_i)
			armed_q <= hit;
		if (rst_i)
			cfg_q <= 8'h00;
		else if (reg_wr_i && hit && armed_q)
			cfg_q <= reg_wdata_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	read_answer_a: assert property (reg_rd_i && hit |=> reg_rdata_valid_o)
		else $error("no read answer");
	write_redirect_a: assert property (reg_wr_i && hit && !armed_q
		|=> remote_count1_wr_o && remote_count1_wdata_o == $past(reg_wdata_i))
		else $error("unarmed write not redirected");
	armed_write_a: assert property (reg_wr_i && hit && armed_q
		|=> !remote_count1_wr_o) else $error("armed write redirected");
	phy_store_a: assert property (phy_type_select_o == cfg_q[1:0])
		else $error("phy type differs");
	pin_group_a: assert property (aui_select_o == ^phy_type_select_o
		&& twisted_pair_mode_o == !aui_select_o) else $error("pin group");
	coax_thin_a: assert property (coax_thin_o == (phy_type_select_o == 2'h1))
		else $error("coax select level");
	link_aui_a: assert property (aui_select_o |-> !link_led_o)
		else $error("link lit in coax mode");
	wide_io_a: assert property (wide_io_o
		== (addr_decode_i && (!cfg_q[3] || io_strobe_i))) else $error("wide io");
	rom_gate_a: assert property (rom_write_o == (rom_write_req_i && cfg_q[6]))
		else $error("rom write gate");
	reload_start_a: assert property (reg_wr_i && hit && armed_q
		&& reg_wdata_i[7] |=> eeprom_reload_trigger_o) else $error("no reload");
	cover property (reg_wr_i && hit && armed_q);
	cover property (remote_count1_wr_o);
	cover property (eeprom_reload_trigger_o);
endmodule : mcrb_config_chk

bind mcrb_config mcrb_config_chk u_mcrb_config_chk (.clk_i, .rst_i, .reg_rd_i,
	.reg_wr_i, .reg_page_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_valid_o,
	.remote_count1_wr_o, .remote_count1_wdata_o, .phy_type_select_o,
	.twisted_pair_mode_o, .aui_select_o, .coax_thin_o, .link_led_o,
	.addr_decode_i, .io_strobe_i, .wide_io_o, .rom_write_req_i, .rom_write_o,
	.eeprom_reload_trigger_o);

// ---- sim/mcrb_host.sv ----
// Host model driving the page-0 register port.
// Assumes one access at a time, launched on falling edges.
module mcrb_host
(
	input  wire logic       clk_i,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rdata_valid_i,
	output logic            reg_rd_o,
	output logic            reg_wr_o,
	output logic [1:0]      reg_page_o,
	output logic [3:0]      reg_addr_o,
	output logic [7:0]      reg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{reg_rd_o, reg_wr_o, reg_page_o, reg_addr_o, reg_wdata_o} = 16'h0000;
	end
	// Plain reads; writes never OR back read data
	task rd(input logic [1:0] p, input logic [3:0] a,
		output logic [7:0] d, output logic v);
		@(negedge clk_i);
		reg_page_o = p;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_i);
		reg_rd_o = 1'b0;
		v = reg_rdata_valid_i;
		d = reg_rdata_i;
	endtask : rd
	task wr(input logic [1:0] p, input logic [3:0] a, input logic [7:0] x);
		@(negedge clk_i);
		reg_page_o = p;
		reg_addr_o = a;
		reg_wdata_o = x;
		reg_wr_o = 1'b1;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		// Released data must not look still valid
		reg_wdata_o = ~x;
	endtask : wr
endmodule : mcrb_host

// ---- sim/mcrb_config_bench.sv ----
// Self-checking bench for the second mode config register bank.
// Assumes host model and checker are compiled ahead of it.
module mcrb_config_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] reg_page_i, phy_type_select_o;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, remote_count1_wdata_o, d;
	logic clk_i, rst_i, reg_rd_i, reg_wr_i, link_integrity_pin_i, v,
		reg_rdata_valid_o, remote_count1_wr_o, twisted_pair_mode_o, aui_select_o,
		coax_thin_o, squelch_reduced_o, link_test_disable_o, link_led_o,
		addr_decode_i, io_strobe_i, cmd_strobe_i, addr_latch_i, wait_abort_i,
		wide_io_o, ready_start_o, rom_write_req_i, rom_write_o,
		eeprom_reload_trigger_o;
	logic [3:0] ph [4] = '{4'h8, 4'h6, 4'h4, 4'h9};
	int num_errors, comparisons, i;
	mcrb_config u_mcrb_config (.clk_i, .rst_i, .reg_rd_i, .reg_wr_i,
		.reg_page_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rdata_valid_o,
		.remote_count1_wr_o, .remote_count1_wdata_o, .link_integrity_pin_i,
		.phy_type_select_o, .twisted_pair_mode_o, .aui_select_o, .coax_thin_o,
		.squelch_reduced_o, .link_test_disable_o, .link_led_o, .addr_decode_i,
		.io_strobe_i, .cmd_strobe_i, .addr_latch_i, .wait_abort_i, .wide_io_o,
		.ready_start_o, .rom_write_req_i, .rom_write_o, .eeprom_reload_trigger_o);
	mcrb_host u_mcrb_host (.clk_i, .reg_rdata_i(reg_rdata_o),
		.reg_rdata_valid_i(reg_rdata_valid_o), .reg_rd_o(reg_rd_i),
		.reg_wr_o(reg_wr_i), .reg_page_o(reg_page_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task summarize;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task rdchk(input logic [7:0] exp);
		u_mcrb_host.rd(2'h0, 4'hb, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask : rdchk
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		rst_i = 1'b1;
		{link_integrity_pin_i, addr_decode_i, io_strobe_i, cmd_strobe_i} = 4'h0;
		{addr_latch_i, wait_abort_i, rom_write_req_i} = 3'h0;
		num_errors = 0;
		comparisons = 0;
		repeat (4) @(negedge clk_i);
		rst_i = 1'b0;
		u_mcrb_host.wr(2'h0, 4'hb, 8'h5a);
		chk({remote_count1_wr_o, remote_count1_wdata_o[6:0]}, 8'hda);
		rdchk(8'h00);
		u_mcrb_host.rd(2'h1, 4'hb, d, v);
		chk({7'h00, v}, 8'h00);
		u_mcrb_host.wr(2'h0, 4'hb, 8'h03);
		chk({remote_count1_wr_o, 5'h00, phy_type_select_o}, 8'h80);
		chk(remote_count1_wdata_o, 8'h03);
		for (i = 0; i < 4; i++)
		begin
			rdchk(8'(i == 0 ? 0 : i - 1));
			u_mcrb_host.wr(2'h0, 4'hb, 8'(i));
			chk({4'h0, twisted_pair_mode_o, aui_select_o, coax_thin_o,
				squelch_reduced_o}, {4'h0, ph[i]});
		end
		link_integrity_pin_i = 1'b1;
		for (i = 0; i < 10 && link_led_o !== 1'b1; i++) @(negedge clk_i);
		chk({7'h00, link_led_o}, 8'h01);
		rdchk(8'h07);
		u_mcrb_host.wr(2'h0, 4'hb, 8'h04);
		link_integrity_pin_i = 1'b0;
		repeat (8) @(negedge clk_i);
		chk({7'h00, link_test_disable_o}, 8'h01);
		rdchk(8'h04);
		wait_abort_i = 1'b1;
		@(negedge clk_i);
		wait_abort_i = 1'b0;
		rdchk(8'h24);
		u_mcrb_host.wr(2'h0, 4'hb, 8'h04);
		rdchk(8'h24);
		// Fault and clearing write in one cycle: the fault must stay
		wait_abort_i = 1'b1;
		u_mcrb_host.wr(2'h0, 4'hb, 8'h24);
		wait_abort_i = 1'b0;
		rdchk(8'h24);
		u_mcrb_host.wr(2'h0, 4'hb, 8'h24);
		rdchk(8'h04);
		u_mcrb_host.wr(2'h0, 4'hb, 8'h5c);
		{addr_decode_i, cmd_strobe_i, rom_write_req_i} = 3'h7;
		@(negedge clk_i);
		chk({5'h00, wide_io_o, ready_start_o, rom_write_o}, 8'h01);
		{io_strobe_i, addr_latch_i} = 2'h3;
		@(negedge clk_i);
		chk({5'h00, wide_io_o, ready_start_o, rom_write_o}, 8'h07);
		rdchk(8'h5c);
		u_mcrb_host.wr(2'h0, 4'hb, 8'h84);
		chk({7'h00, eeprom_reload_trigger_o}, 8'h01);
		{io_strobe_i, cmd_strobe_i} = 2'h0;
		@(negedge clk_i);
		chk({5'h00, wide_io_o, ready_start_o, rom_write_o}, 8'h04);
		rdchk(8'h04);
		summarize();
	end
endmodule : mcrb_config_bench
